// ---- rtl/imu_ctrl_defs.svh ----
// Register offsets, field positions, reset values and timing figures
`ifndef IMU_CTRL_DEFS_SVH
`define IMU_CTRL_DEFS_SVH
`define ADR_RATE_OFF_X 7'h1A
`define ADR_ACCEL_OFF_X 7'h20
`define ADR_AUX_DAC 7'h30
`define ADR_PIN_IO 7'h32
`define ADR_MISC 7'h34
`define ADR_SAMPLE 7'h36
`define ADR_RANGE 7'h38
`define ADR_SLEEP 7'h3A
`define ADR_GLOBAL 7'h3E
`define FRAME_WR_BIT 15
`define CMD_AUTONULL 0
`define CMD_RESTORE 1
`define CMD_DAC_LATCH 2
`define CMD_FLASH 3
`define CMD_PRECISE 4
`define CMD_SW_RESET 7
`define CMD_MASK 8'h9F
`define MISC_MASK 8'hC7
`define MISC_COMP_BIT 7
`define MISC_DR_EN_BIT 2
`define MISC_DR_POL_BIT 1
`define MISC_DR_SEL_BIT 0
`define SAMPLE_TB_BIT 7
`define SLEEP_IND_BIT 0
`define LOW_POWER_MIN 8'h0A
`define RANGE_300 3'h4
`define RANGE_150 3'h2
`define RANGE_75 3'h1
`define MIN_EXP_150 3'h2
`define MIN_EXP_75 3'h4
`define RST_MISC 8'h06
`define RST_SAMPLE 8'h01
`define RST_RANGE 3'h4
`define RST_TAPS 3'h2
`define CLK_PERIOD_NS 50.0
`define TB_FAST_MS 0.61035
`define TB_SLOW_MS 18.921
`define FLASH_MAX_MS 50.0
`define PRECISE_S 30.0
`define SLEEP_UNIT_S 0.5
`endif

// ---- rtl/imu_ctrl_pkg.sv ----
// Types shared by the control register bank and its testbench
package imu_ctrl_pkg;
    typedef logic [2:0][13:0] rate_t;
    typedef logic [2:0][12:0] bias_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_OFFLINE = 4'b0010,
        ST_FLASH = 4'b0100,
        ST_LOAD = 4'b1000
    } seq_e;
    typedef struct packed {
        logic [2:0][11:0] accel;
        logic [2:0][12:0] rate;
    } cal_s;
    typedef struct packed {
        cal_s cal;
        logic [7:0] misc;
        logic [7:0] sample;
        logic [2:0] range;
        logic [2:0] taps;
        logic [3:0] pin_dir;
        logic [3:0] pin_level;
    } image_s;
    typedef struct packed {
        seq_e seq;
        logic [31:0] timer;
        logic [7:0] cmd;
        logic [7:0] ops;
        image_s regs;
        logic [11:0] aux_dac;
        logic [11:0] dac_out;
        logic sclk_q;
        logic cs_q;
        logic [3:0] bitcnt;
        logic [15:0] shin;
        logic [15:0] shout;
        logic [15:0] resp;
        logic dout;
        logic burst;
        logic asleep_ind;
        logic [7:0] sleep_cnt;
        logic [31:0] sleep_tmr;
        logic [31:0] tb_cnt;
        logic [6:0] inc_cnt;
        logic tick;
        logic clear;
        logic [3:0] pin_in_q;
        logic [3:0] pin_out;
        logic [3:0] pin_oe_n;
    } ctrl_state_s;
endpackage

// ---- rtl/bartlett_filter.sv ----
// Two cascaded moving-average stages with 2**exp taps each
`timescale 1ns/1ps
module bartlett_filter #(
    parameter int W = 14,
    parameter int MAX_EXP = 7
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic advance,
    input wire logic clear,
    input wire logic [2:0] exp,
    input wire logic [W-1:0] sample,
    output logic [W-1:0] result
);
    localparam int DEPTH = 2 ** MAX_EXP;
    localparam int SW = W + MAX_EXP;
    typedef struct packed {
        logic [MAX_EXP-1:0] ptr;
        logic [MAX_EXP:0] fill;
        logic [2:0] exp_q;
        logic signed [SW-1:0] sum1;
        logic signed [SW-1:0] sum2;
        logic [W-1:0] result;
    } filt_state_s;

    filt_state_s r_reg;
    filt_state_s r_next;
    logic [W-1:0] mem1 [DEPTH];
    logic [W-1:0] mem2 [DEPTH];
    logic [MAX_EXP:0] taps;
    logic [MAX_EXP-1:0] rd;
    logic [W-1:0] old1;
    logic [W-1:0] old2;
    logic signed [SW-1:0] sum1_n;
    logic signed [SW-1:0] sum2_n;
    logic [W-1:0] avg1;
    logic wr;

    // Running sums: add newest, drop the sample that left the window
    always_comb begin
        taps = (MAX_EXP + 1)'(1) << exp;
        rd = r_reg.ptr - taps[MAX_EXP-1:0];
        old1 = (r_reg.fill >= taps) ? mem1[rd] : '0;
        old2 = (r_reg.fill >= taps) ? mem2[rd] : '0;
        sum1_n = r_reg.sum1 + SW'($signed(sample)) - SW'($signed(old1));
        avg1 = W'(sum1_n >>> exp);
        sum2_n = r_reg.sum2 + SW'($signed(avg1)) - SW'($signed(old2));
        r_next = r_reg;
        wr = 1'b0;
        if (clear || exp != r_reg.exp_q) begin
            r_next = '0; // Window restarts empty on a new length
            r_next.exp_q = exp;
        end else if (advance) begin
            r_next.sum1 = sum1_n;
            r_next.sum2 = sum2_n;
            r_next.result = W'(sum2_n >>> exp);
            r_next.ptr = r_reg.ptr + 1'b1;
            if (r_reg.fill < taps) begin
                r_next.fill = r_reg.fill + 1'b1;
            end
            wr = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // Sample history of both stages
    always_ff @(posedge clk) begin
        if (wr) begin
            mem1[r_reg.ptr] <= sample;
            mem2[r_reg.ptr] <= avg1;
        end
    end

    assign result = r_reg.result;
endmodule

// ---- rtl/imu_control_registers.sv ----
// Configuration and command register bank of a six-axis inertial sensor
//
// Overview of operation
// - accel offsets hold 12-bit twos complement value
// - autonull loads negated gyro outputs, then saves
// - precision autonull goes offline, loads refined bias
// - factory restore zeroes all calibration offsets
// - misc bit 7 enables linear acceleration compensation
// - command bits self-clear when operation completes
// - software reset reloads control registers from flash
// - reading global command starts burst read
// - bit 3 saves flash, bit 2 latches DAC
// - sample period is timebase times increment plus one
// - sample period resets to one
// - period value 0x0A or more means low power
// - bit 8 sleeps until chip select falls
// - nonzero sleep count sleeps half seconds each
// - two cascaded averaging stages of 2**M taps
// - range bits select 300, 150 or 75 deg/s
// - lower ranges force a minimum tap exponent
// - pin owner: data ready, then alarm, then register
// - pin control bits 3:0 set pin directions
// - bits 11:8 drive outputs, read input pin states
// - gyro offsets hold 13-bit twos complement value
// - 16-bit registers split into two byte addresses
`timescale 1ns/1ps
`include "imu_ctrl_defs.svh"
module imu_control_registers #(
    parameter int unsigned TB_FAST_CYC =
        int'(`TB_FAST_MS * 1.0E6 / `CLK_PERIOD_NS),
    parameter int unsigned TB_SLOW_CYC =
        int'(`TB_SLOW_MS * 1.0E6 / `CLK_PERIOD_NS),
    parameter int unsigned FLASH_MAX_CYC =
        int'($floor(`FLASH_MAX_MS * 1.0E6 / `CLK_PERIOD_NS)),
    parameter int unsigned PRECISE_CYC =
        int'(`PRECISE_S * 1.0E9 / `CLK_PERIOD_NS),
    parameter int unsigned SLEEP_UNIT_CYC =
        int'(`SLEEP_UNIT_S * 1.0E9 / `CLK_PERIOD_NS),
    parameter int MAX_EXP = 7
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic DIN,
    output logic DOUT,
    output logic BURST_START,
    input wire imu_ctrl_pkg::rate_t RATE_RAW,
    input wire imu_ctrl_pkg::bias_t REFINED_BIAS,
    output imu_ctrl_pkg::rate_t RATE_FILTERED,
    output imu_ctrl_pkg::cal_s CAL,
    output logic DATA_CLEAR,
    output logic SAMPLE_TICK,
    output logic LOW_POWER,
    output logic ASLEEP,
    output logic SENSOR_HALT,
    output logic LIN_ACCEL_COMP,
    output logic [2:0] RANGE_SEL,
    output logic [2:0] FILTER_EXP,
    output logic [11:0] DAC_VALUE,
    output logic FLASH_SAVE_REQ,
    output imu_ctrl_pkg::image_s FLASH_SAVE_IMAGE,
    output logic FLASH_LOAD_REQ,
    input wire logic FLASH_DONE,
    input wire imu_ctrl_pkg::image_s FLASH_LOAD_IMAGE,
    input wire logic DATA_READY,
    input wire logic [3:0] ALARM_OWN,
    input wire logic [3:0] ALARM_LEVEL,
    input wire logic [3:0] PIN_IN,
    output logic [3:0] PIN_OUT,
    output logic [3:0] PIN_OE_N
);
    import imu_ctrl_pkg::*;

    localparam image_s IMAGE_RESET = '{
        cal: '0,
        misc: `RST_MISC,
        sample: `RST_SAMPLE,
        range: `RST_RANGE,
        taps: `RST_TAPS,
        pin_dir: 4'h0,
        pin_level: 4'h0
    };

    ctrl_state_s r_reg;
    ctrl_state_s r_next;

    // Word address match; either byte of a register hits it
    function automatic logic hit(input logic [6:0] a, input logic [6:0] b);
        return a[6:1] == b[6:1];
    endfunction

    // Least tap exponent that a range allows
    function automatic logic [2:0] min_exp(input logic [2:0] range);
        case (range)
            `RANGE_150: return `MIN_EXP_150;
            `RANGE_75: return `MIN_EXP_75;
            default: return 3'h0;
        endcase
    endfunction

    // Raise a tap exponent to the range minimum
    function automatic logic [2:0] enforce(input logic [2:0] m,
                                           input logic [2:0] range);
        return (m < min_exp(range)) ? min_exp(range) : m;
    endfunction

    // Negated rate output rescaled to offset units, saturated to 13 bits
    function automatic logic [12:0] null_bias(input logic [13:0] raw);
        logic signed [16:0] ext;
        logic signed [16:0] v;
        ext = $signed({{3{raw[13]}}, raw});
        v = -(ext <<< 2);
        if (v > 17'sh00FFF) begin
            return 13'h0FFF;
        end else if (v < -17'sh01000) begin
            return 13'h1000;
        end
        return v[12:0];
    endfunction

    // Read view of one register word
    function automatic logic [15:0] reg_read(input logic [6:0] a,
                                             input image_s im,
                                             input logic [11:0] dac,
                                             input logic [3:0] pins);
        logic [15:0] v;
        logic [3:0] lvl;
        v = 16'h0000;
        lvl = (im.pin_dir & im.pin_level) | (~im.pin_dir & pins);
        for (int i = 0; i < 3; i++) begin
            if (hit(a, 7'(`ADR_ACCEL_OFF_X + 2 * i))) begin
                v = {4'h0, im.cal.accel[i]};
            end
            if (hit(a, 7'(`ADR_RATE_OFF_X + 2 * i))) begin
                v = {3'h0, im.cal.rate[i]};
            end
        end
        if (hit(a, `ADR_MISC)) begin
            v = {8'h00, im.misc};
        end
        if (hit(a, `ADR_SAMPLE)) begin
            v = {8'h00, im.sample};
        end
        if (hit(a, `ADR_RANGE)) begin
            v = {5'h00, im.range, 5'h00, im.taps};
        end
        if (hit(a, `ADR_PIN_IO)) begin
            v = {4'h0, lvl, 4'h0, im.pin_dir};
        end
        if (hit(a, `ADR_AUX_DAC)) begin
            v = {4'h0, dac};
        end
        return v;
    endfunction

    // Serial port, command sequencer, sleep, timebase and pin ownership
    always_comb begin
        logic [15:0] frame;
        logic [6:0] adr;
        logic [7:0] dat;
        logic hi;
        logic done;
        logic wr;
        logic halted;
        logic [31:0] tb;
        frame = {r_reg.shin[14:0], DIN};
        adr = frame[14:8];
        dat = frame[7:0];
        hi = adr[0];
        done = 1'b0;
        wr = 1'b0;
        halted = r_reg.asleep_ind || (r_reg.sleep_cnt != 8'h00) ||
                 r_reg.seq == ST_OFFLINE || r_reg.seq == ST_LOAD;
        tb = r_reg.regs.sample[`SAMPLE_TB_BIT] ? 32'(TB_SLOW_CYC) :
                                                 32'(TB_FAST_CYC);
        r_next = r_reg;
        r_next.sclk_q = SCLK;
        r_next.cs_q = CS_N;
        r_next.burst = 1'b0;
        r_next.tick = 1'b0;
        r_next.clear = 1'b0;
        r_next.pin_in_q = PIN_IN;

        // Frame shifter: sample on rising, drive on falling clock edge
        if (r_reg.cs_q && !CS_N) begin
            r_next.bitcnt = 4'h0;
            r_next.shout = r_reg.resp;
            r_next.dout = r_reg.resp[15];
        end else if (!CS_N && SCLK && !r_reg.sclk_q) begin
            r_next.shin = frame;
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
            done = (r_reg.bitcnt == 4'hF);
        end else if (!CS_N && !SCLK && r_reg.sclk_q) begin
            r_next.dout = r_reg.shout[15];
            r_next.shout = {r_reg.shout[14:0], 1'b0};
        end
        wr = done && frame[`FRAME_WR_BIT];
        if (done && !frame[`FRAME_WR_BIT]) begin
            if (hit(adr, `ADR_GLOBAL)) begin
                r_next.burst = 1'b1;
                r_next.resp = 16'h0000;
            end else begin
                r_next.resp = reg_read(adr, r_reg.regs, r_reg.aux_dac,
                                       r_reg.pin_in_q);
            end
        end

        // Command sequencer
        case (r_reg.seq)
            ST_IDLE: begin
                r_next.timer = 32'h0000_0000;
                if (r_reg.cmd[`CMD_SW_RESET]) begin
                    r_next.seq = ST_LOAD;
                end else if (r_reg.cmd[`CMD_RESTORE]) begin
                    r_next.regs.cal = '0;
                    r_next.clear = 1'b1;
                    r_next.ops = 8'(1 << `CMD_RESTORE);
                    r_next.seq = ST_FLASH;
                end else if (r_reg.cmd[`CMD_AUTONULL]) begin
                    for (int i = 0; i < 3; i++) begin
                        r_next.regs.cal.rate[i] = null_bias(RATE_RAW[i]);
                    end
                    r_next.clear = 1'b1;
                    r_next.ops = 8'(1 << `CMD_AUTONULL);
                    r_next.seq = ST_FLASH;
                end else if (r_reg.cmd[`CMD_PRECISE]) begin
                    r_next.seq = ST_OFFLINE;
                end else if (r_reg.cmd[`CMD_FLASH]) begin
                    r_next.ops = 8'(1 << `CMD_FLASH);
                    r_next.seq = ST_FLASH;
                end else if (r_reg.cmd[`CMD_DAC_LATCH]) begin
                    r_next.dac_out = r_reg.aux_dac;
                    r_next.cmd[`CMD_DAC_LATCH] = 1'b0;
                end
            end
            ST_OFFLINE: begin
                r_next.timer = r_reg.timer + 32'h1;
                if (r_reg.timer == 32'(PRECISE_CYC - 1)) begin
                    r_next.regs.cal.rate = REFINED_BIAS;
                    r_next.clear = 1'b1;
                    r_next.ops = 8'(1 << `CMD_PRECISE);
                    r_next.timer = 32'h0000_0000;
                    r_next.seq = ST_FLASH;
                end
            end
            ST_FLASH: begin
                r_next.timer = r_reg.timer + 32'h1;
                if (FLASH_DONE || r_reg.timer == 32'(FLASH_MAX_CYC - 1)) begin
                    // A save covers a pending flash request as well
                    r_next.cmd = r_reg.cmd & ~(r_reg.ops |
                                 8'(1 << `CMD_FLASH));
                    r_next.ops = 8'h00;
                    r_next.seq = ST_IDLE;
                end
            end
            ST_LOAD: begin
                r_next.timer = r_reg.timer + 32'h1;
                if (FLASH_DONE || r_reg.timer == 32'(FLASH_MAX_CYC - 1)) begin
                    r_next.regs = FLASH_DONE ? FLASH_LOAD_IMAGE : IMAGE_RESET;
                    r_next.regs.misc = r_next.regs.misc & `MISC_MASK;
                    r_next.regs.taps = enforce(r_next.regs.taps,
                                               r_next.regs.range);
                    r_next.clear = 1'b1;
                    r_next.cmd = 8'h00;
                    r_next.seq = ST_IDLE;
                end
            end
            default: begin
                r_next.seq = ST_IDLE;
            end
        endcase

        // Sleep: indefinite until chip select falls, or counted halves
        if (r_reg.asleep_ind && r_reg.cs_q && !CS_N) begin
            r_next.asleep_ind = 1'b0;
        end
        if (r_reg.sleep_cnt != 8'h00) begin
            r_next.sleep_tmr = r_reg.sleep_tmr + 32'h1;
            if (r_reg.sleep_tmr == 32'(SLEEP_UNIT_CYC - 1)) begin
                r_next.sleep_tmr = 32'h0000_0000;
                r_next.sleep_cnt = r_reg.sleep_cnt - 8'h01;
            end
        end

        // Internal sample timebase, halted while asleep or offline
        if (halted) begin
            r_next.tb_cnt = 32'h0000_0000;
            r_next.inc_cnt = 7'h00;
        end else begin
            r_next.tb_cnt = r_reg.tb_cnt + 32'h1;
            if (r_reg.tb_cnt >= tb - 32'h1) begin
                r_next.tb_cnt = 32'h0000_0000;
                if (r_reg.inc_cnt >= r_reg.regs.sample[6:0]) begin
                    r_next.inc_cnt = 7'h00;
                    r_next.tick = 1'b1;
                end else begin
                    r_next.inc_cnt = r_reg.inc_cnt + 7'h01;
                end
            end
        end

        // Register writes, one byte per frame
        if (wr) begin
            for (int i = 0; i < 3; i++) begin
                if (hit(adr, 7'(`ADR_ACCEL_OFF_X + 2 * i))) begin
                    if (hi) begin
                        r_next.regs.cal.accel[i][11:8] = dat[3:0];
                    end else begin
                        r_next.regs.cal.accel[i][7:0] = dat;
                    end
                end
                if (hit(adr, 7'(`ADR_RATE_OFF_X + 2 * i))) begin
                    if (hi) begin
                        r_next.regs.cal.rate[i][12:8] = dat[4:0];
                    end else begin
                        r_next.regs.cal.rate[i][7:0] = dat;
                    end
                end
            end
            if (hit(adr, `ADR_GLOBAL) && !hi) begin
                r_next.cmd = r_next.cmd | (dat & `CMD_MASK);
            end
            if (hit(adr, `ADR_MISC) && !hi) begin
                r_next.regs.misc = dat & `MISC_MASK;
            end
            if (hit(adr, `ADR_SAMPLE) && !hi) begin
                r_next.regs.sample = dat;
            end
            if (hit(adr, `ADR_RANGE)) begin
                if (hi && dat[7:3] == 5'h00 && (dat[2:0] == `RANGE_300 ||
                    dat[2:0] == `RANGE_150 || dat[2:0] == `RANGE_75)) begin
                    r_next.regs.range = dat[2:0];
                    r_next.regs.taps = enforce(r_next.regs.taps,
                                               dat[2:0]);
                end else if (!hi) begin
                    r_next.regs.taps = enforce(dat[2:0],
                                               r_next.regs.range);
                end
            end
            if (hit(adr, `ADR_SLEEP)) begin
                if (hi && dat[`SLEEP_IND_BIT]) begin
                    r_next.asleep_ind = 1'b1;
                end else if (!hi && dat != 8'h00) begin
                    r_next.sleep_cnt = dat;
                    r_next.sleep_tmr = 32'h0000_0000;
                end
            end
            if (hit(adr, `ADR_PIN_IO)) begin
                if (hi) begin
                    r_next.regs.pin_level = dat[3:0];
                end else begin
                    r_next.regs.pin_dir = dat[3:0];
                end
            end
            if (hit(adr, `ADR_AUX_DAC)) begin
                if (hi) begin
                    r_next.aux_dac[11:8] = dat[3:0];
                end else begin
                    r_next.aux_dac[7:0] = dat;
                end
            end
        end

        // Pin ownership by priority
        for (int i = 0; i < 4; i++) begin
            if (r_reg.regs.misc[`MISC_DR_EN_BIT] &&
                i == int'(r_reg.regs.misc[`MISC_DR_SEL_BIT])) begin
                r_next.pin_out[i] = r_reg.regs.misc[`MISC_DR_POL_BIT] ?
                                    DATA_READY : !DATA_READY;
                r_next.pin_oe_n[i] = 1'b0;
            end else if (ALARM_OWN[i]) begin
                r_next.pin_out[i] = ALARM_LEVEL[i];
                r_next.pin_oe_n[i] = 1'b0;
            end else begin
                r_next.pin_out[i] = r_reg.regs.pin_level[i];
                r_next.pin_oe_n[i] = !r_reg.regs.pin_dir[i];
            end
        end
    end

    // State register
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            r_reg <= '0;
            r_reg.seq <= ST_IDLE;
            r_reg.regs <= IMAGE_RESET;
            r_reg.sclk_q <= 1'b1;
            r_reg.cs_q <= 1'b1;
            r_reg.pin_oe_n <= 4'hF;
        end else begin
            r_reg <= r_next;
        end
    end

    // Output filter per gyro axis
    generate
        for (genvar g = 0; g < 3; g++) begin : g_axis
            bartlett_filter #(
                .W(14),
                .MAX_EXP(MAX_EXP)
            ) u_filter (
                .clk(CLK),
                .rst_n(RSTN),
                .advance(r_reg.tick),
                .clear(r_reg.clear),
                .exp(r_reg.regs.taps),
                .sample(RATE_RAW[g]),
                .result(RATE_FILTERED[g])
            );
        end
    endgenerate

    // Outputs straight from state
    assign DOUT = r_reg.dout;
    assign BURST_START = r_reg.burst;
    assign CAL = r_reg.regs.cal;
    assign DATA_CLEAR = r_reg.clear;
    assign SAMPLE_TICK = r_reg.tick;
    assign LOW_POWER = r_reg.regs.sample >= `LOW_POWER_MIN;
    assign ASLEEP = r_reg.asleep_ind || (r_reg.sleep_cnt != 8'h00);
    assign SENSOR_HALT = r_reg.seq == ST_OFFLINE || r_reg.seq == ST_LOAD;
    assign LIN_ACCEL_COMP = r_reg.regs.misc[`MISC_COMP_BIT];
    assign RANGE_SEL = r_reg.regs.range;
    assign FILTER_EXP = r_reg.regs.taps;
    assign DAC_VALUE = r_reg.dac_out;
    assign FLASH_SAVE_REQ = r_reg.seq == ST_FLASH;
    assign FLASH_SAVE_IMAGE = r_reg.regs;
    assign FLASH_LOAD_REQ = r_reg.seq == ST_LOAD;
    assign PIN_OUT = r_reg.pin_out;
    assign PIN_OE_N = r_reg.pin_oe_n;
endmodule

// ---- verif/imu_ctrl_checker.sv ----
// Port assertions for the control register bank
`timescale 1ns/1ps
module imu_ctrl_checker (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic SAMPLE_TICK,
    input wire logic SENSOR_HALT,
    input wire logic ASLEEP,
    input wire logic DATA_CLEAR,
    input wire logic FLASH_SAVE_REQ,
    input wire logic FLASH_DONE,
    input wire logic [2:0] RANGE_SEL,
    input wire logic [2:0] FILTER_EXP
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // Clear is a single-cycle pulse
    sequence s_clr;
        DATA_CLEAR ##1 !DATA_CLEAR;
    endsequence
    // Timing and range relations seen at the ports
    a_halt_no_tick: assert property (SENSOR_HALT && $past(SENSOR_HALT)
        |-> !SAMPLE_TICK) else $error("tick while halted");
    a_sleep_no_tick: assert property (ASLEEP && $past(ASLEEP)
        |-> !SAMPLE_TICK) else $error("tick while asleep");
    a_tick_one_cycle: assert property (SAMPLE_TICK |=> !SAMPLE_TICK)
        else $error("tick too long");
    a_clear_one_cycle: assert property (DATA_CLEAR |-> s_clr)
        else $error("clear too long");
    a_range_code_legal: assert property (RANGE_SEL inside {3'h4, 3'h2,
        3'h1}) else $error("bad range code");
    a_taps_min_mid: assert property (RANGE_SEL == 3'h2 |-> FILTER_EXP
        >= 3'h2) else $error("taps below mid minimum");
    a_taps_min_low: assert property (RANGE_SEL == 3'h1 |-> FILTER_EXP
        >= 3'h4) else $error("taps below low minimum");
    a_save_done_ends: assert property (FLASH_SAVE_REQ && FLASH_DONE
        |=> !FLASH_SAVE_REQ) else $error("save held after done");
endmodule
bind imu_control_registers imu_ctrl_checker chk_u (.CLK, .RSTN,
    .SAMPLE_TICK, .SENSOR_HALT, .ASLEEP, .DATA_CLEAR, .FLASH_SAVE_REQ,
    .FLASH_DONE, .RANGE_SEL, .FILTER_EXP);

// ---- verif/imu_host.sv ----
// Host processor model driving the serial register port
`timescale 1ns/1ps
module imu_host (
    input wire logic CLK,
    input wire logic DOUT,
    output logic SCLK = 1'b1, // Idles high between frames
    output logic CS_N = 1'b1,
    output logic DIN = 1'b0
);
    // One 16-bit frame, MSB first, address then byte
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        @(negedge CLK);
        CS_N = 1'b0;
        repeat (2) @(negedge CLK);
        for (int i = 15; i >= 0; i--) begin
            SCLK = 1'b0;
            DIN = w[i];
            repeat (2) @(negedge CLK);
            r[i] = DOUT;
            SCLK = 1'b1;
            repeat (2) @(negedge CLK);
        end
        CS_N = 1'b1;
        DIN = ~DIN; // Released data line does not keep its value
        repeat (2) @(negedge CLK);
    endtask
endmodule

// ---- verif/imu_control_registers_test.sv ----
// Self-checking testbench of the control register bank
`timescale 1ns/1ps
module imu_control_registers_test;
    import imu_ctrl_pkg::*;
    logic CLK = 0, RSTN = 0, FLASH_DONE = 0, DATA_READY = 0, FLASH_LOAD_REQ;
    logic SCLK, CS_N, DIN, DOUT, BURST_START, DATA_CLEAR, SAMPLE_TICK;
    logic LOW_POWER, ASLEEP, SENSOR_HALT, LIN_ACCEL_COMP, FLASH_SAVE_REQ;
    logic [2:0] RANGE_SEL, FILTER_EXP;
    logic [11:0] DAC_VALUE;
    logic [3:0] ALARM_OWN = '0, ALARM_LEVEL = '0, PIN_IN = 4'h2;
    logic [3:0] PIN_OUT, PIN_OE_N;
    rate_t RATE_RAW = '0, RATE_FILTERED;
    bias_t REFINED_BIAS = '0;
    cal_s CAL;
    image_s FLASH_SAVE_IMAGE, FLASH_LOAD_IMAGE = '0;
    int n_mismatch = 0, tests_run = 0, n_burst = 0, n_save = 0;
    logic [15:0] rd_v;
    always #25 CLK = ~CLK;
    imu_control_registers #(.TB_FAST_CYC(4), .TB_SLOW_CYC(8),
        .FLASH_MAX_CYC(20), .PRECISE_CYC(30), .SLEEP_UNIT_CYC(10))
        dut_u (.*);
    imu_host host_u (.CLK(CLK), .DOUT(DOUT), .SCLK(SCLK), .CS_N(CS_N),
        .DIN(DIN));
    // Flash store answers promptly; burst starts are counted
    always @(negedge CLK)
        FLASH_DONE <= (FLASH_SAVE_REQ | FLASH_LOAD_REQ) & ~FLASH_DONE;
    always @(negedge CLK) if (BURST_START === 1'b1) n_burst++;
    always @(negedge CLK) if (FLASH_SAVE_REQ === 1'b1 && !FLASH_DONE) n_save++;
    task automatic chk(input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] w);
        host_u.xfer(w, rd_v);
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        host_u.xfer({1'b0, a, 8'h00}, rd_v);
        host_u.xfer(16'h0000, rd_v);
        chk(rd_v, e);
    endtask
    task automatic wt(ref logic s, input logic v);
        for (int i = 0; i < 300 && s !== v; i++) @(negedge CLK);
    endtask
    // Cycles between the first and second tick
    task automatic period(input int exp);
        int n = 0;
        wt(SAMPLE_TICK, 1'b1);
        @(negedge CLK);
        for (; n < 100 && SAMPLE_TICK !== 1'b1; n++) @(negedge CLK);
        chk(16'(n + 1), 16'(exp));
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog against a hung sequence
    initial begin
        repeat (20000) @(posedge CLK);
        n_mismatch++;
        give_verdict();
    end
    // Main sequence
    initial begin
        repeat (8) @(negedge CLK);
        RSTN = 1'b1;
        rd(7'h36, 16'h0001);
        rd(7'h38, 16'h0402);
        wr(16'hA1FF);
        wr(16'hA0FF);
        rd(7'h20, 16'h0FFF);
        wr(16'hB800);
        wr(16'hB902);
        rd(7'h38, 16'h0202);
        wr(16'hB901);
        wr(16'hB903);
        rd(7'h38, 16'h0104);
        wr(16'hB904);
        $display("offsets and range done");
        wr(16'hB486);
        chk(16'(LIN_ACCEL_COMP), 16'h0001);
        wr(16'hB60A);
        chk(16'(LOW_POWER), 16'h0001);
        wr(16'hB609);
        chk(16'(LOW_POWER), 16'h0000);
        wr(16'hB601);
        period(8);
        wr(16'hB681);
        period(16);
        $display("timebase done");
        RATE_RAW[0] = 14'h0001;
        wr(16'hBE01);
        rd(7'h1A, 16'h1FFC);
        wr(16'h3E00);
        chk(16'(n_burst), 16'h0001);
        wr(16'hBE02);
        chk(16'(CAL == '0), 16'h0001);
        REFINED_BIAS[1] = 13'h0123;
        wr(16'hBE10);
        chk(16'(SENSOR_HALT), 16'h0001);
        wt(SENSOR_HALT, 1'b0);
        rd(7'h1C, 16'h0123);
        wr(16'hB0D9);
        wr(16'hB104);
        wr(16'hBE04);
        chk(16'(DAC_VALUE), 16'h04D9);
        wr(16'hBE08);
        chk(16'(n_save), 16'h0004);
        $display("commands done");
        wr(16'hBB01);
        chk(16'(ASLEEP), 16'h0001);
        wr(16'h0000);
        chk(16'(ASLEEP), 16'h0000);
        wr(16'hBA03);
        chk(16'(ASLEEP), 16'h0001);
        repeat (30) @(negedge CLK);
        chk(16'(ASLEEP), 16'h0000);
        DATA_READY = 1'b1;
        ALARM_OWN = 4'h8;
        wr(16'hB308);
        wr(16'hB20C);
        chk(16'(PIN_OE_N), 16'h0002);
        chk(16'(PIN_OUT), 16'h0001);
        rd(7'h32, 16'h0A0C);
        FLASH_LOAD_IMAGE.sample = 8'h05;
        FLASH_LOAD_IMAGE.range = 3'h4;
        wr(16'hBE80);
        rd(7'h36, 16'h0005);
        chk(16'(FLASH_SAVE_IMAGE.sample), 16'h0005);
        chk(16'(RATE_FILTERED[0]), 16'h0001);
        $display("sleep, pins and restart done");
        give_verdict();
    end
endmodule
